// [hw/hex_loader_defines.vh]
// constants for the ascii hex record loader
// Operation
// (R1) a colon starts a new record; fixed fields follow it
// (R2) between records every non-colon character is ignored
// (R3) sender uses upper-case hex digits; lower case may be rejected
// (R4) load addresses are 20 bits, from 16-bit segment and offset
// (R5) address equals segment shifted left four plus offset
// (R6) low eight bits of sum of all bytes, checksum included, must be zero
// (R7) type 02 record, length 02: two data bytes give new segment
// (R8) segment is zero after reset and sticks until replaced
// (R9) length byte counts only data bytes
// (R10) type 00 data goes to offset plus segment, rising by one per byte
// (R11) type 03 record, length 04: segment*16 plus offset is start address
// (R12) type 01 record, length 00, ends the download
// (R13) sender sends exactly one end record and nothing after it
// (R14) bad checksum or unknown type writes nothing, sets sticky error
`ifndef HEX_LOADER_DEFINES_VH
`define HEX_LOADER_DEFINES_VH

// ==========================================================
// characters
`define CH_START    8'h3A
`define CH_ZERO     8'h30
`define CH_NINE     8'h39
`define CH_UPPER_A  8'h41
`define CH_UPPER_F  8'h46

// ==========================================================
// record types and fixed lengths
`define REC_DATA    8'h00
`define REC_EOF     8'h01
`define REC_SEG     8'h02
`define REC_START   8'h03
`define LEN_SEG     8'h02
`define LEN_START   8'h04

// ==========================================================
// field positions in the header byte stream, segment shift and segment reset value
`define POS_LEN     3'h0
`define POS_ADDR_HI 3'h1
`define POS_ADDR_LO 3'h2
`define POS_TYPE    3'h3
`define SEG_SHIFT   4
`define SEG_RESET   16'h0000

`endif

// [hw/hex_record_loader.v]
// ascii hex record parser that writes bytes to local memory
`timescale 1ns/10ps
`include "hex_loader_defines.vh"
module hex_record_loader #(
  parameter MAX_DATA = 255
) (
  input  wire        core_clk_i,    // clock, 10 MHz
  input  wire        srst_i,        // sync reset, active high
  input  wire [7:0]  rx_char_i,     // received character
  input  wire        rx_valid_i,    // character valid
  output reg         rx_ready_o,    // parser can take a character
  output reg  [19:0] mem_addr_o,    // write address
  output reg  [7:0]  mem_data_o,    // write byte
  output reg         mem_valid_o,   // write request
  input  wire        mem_ready_i,   // memory accepts write
  output reg  [19:0] start_addr_o,  // captured start address
  output reg         start_valid_o, // start address seen
  output reg         done_o,        // end record received
  output reg         error_o        // sticky record error
);
  // ==========================================================
  // states, one-hot
  localparam S_IDLE = 6'b000001;
  localparam S_HEAD = 6'b000010;
  localparam S_DATA = 6'b000100;
  localparam S_SUM  = 6'b001000;
  localparam S_PUSH = 6'b010000;
  localparam S_DONE = 6'b100000;

  // upper-case hex digit value, bit 4 flags a bad character
  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= `CH_ZERO && c <= `CH_NINE)
        hex_val = {1'b0, c[3:0]};
      else if (c >= `CH_UPPER_A && c <= `CH_UPPER_F)
        hex_val = {1'b0, c[3:0] + 4'h9};
      else
        hex_val = 5'h10;
    end
  endfunction

  reg  [5:0]  state_q;
  reg         nib_q;          // high nibble held
  reg  [3:0]  hi_q;
  reg  [2:0]  pos_q;          // header byte index
  reg  [7:0]  len_q;
  reg  [15:0] addr_q;
  reg  [7:0]  type_q;
  reg  [7:0]  sum_q;
  reg  [7:0]  cnt_q;          // data bytes taken
  reg  [15:0] seg_q;
  reg  [7:0]  dbuf_q [0:MAX_DATA-1];
  reg  [7:0]  rd_q;           // push index
  reg  [7:0]  pay0_q;
  reg  [7:0]  pay1_q;
  reg  [7:0]  pay2_q;
  reg  [7:0]  pay3_q;
  wire [4:0]  dig;
  wire        take;
  wire [7:0]  byte_w;
  wire        byte_done;
  wire        buf_in_ready;
  wire [27:0] buf_out;
  wire        buf_out_valid;
  wire        buf_pop;
  wire [19:0] push_addr;

  assign dig       = hex_val(rx_char_i);
  assign take      = rx_valid_i & rx_ready_o;
  assign byte_w    = {hi_q, dig[3:0]};
  assign byte_done = take & nib_q & ~dig[4];
  assign buf_pop   = buf_out_valid & (~mem_valid_o | mem_ready_i);
  // data address: offset plus paragraph-aligned segment, 20 bits
  assign push_addr = {seg_q, 4'h0} + {4'h0, addr_q + {8'h00, rd_q}}; // [R4] [R5] [R10]

  // ==========================================================
  // parser
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q       <= S_IDLE;
      nib_q         <= 1'b0;
      hi_q          <= 4'h0;
      pos_q         <= 3'h0;
      len_q         <= 8'h00;
      addr_q        <= 16'h0000;
      type_q        <= 8'h00;
      sum_q         <= 8'h00;
      cnt_q         <= 8'h00;
      seg_q         <= `SEG_RESET; // [R8]
      rd_q          <= 8'h00;
      pay0_q        <= 8'h00;
      pay1_q        <= 8'h00;
      pay2_q        <= 8'h00;
      pay3_q        <= 8'h00;
      rx_ready_o    <= 1'b0;
      start_addr_o  <= 20'h00000;
      start_valid_o <= 1'b0;
      done_o        <= 1'b0;
      error_o       <= 1'b0;
    end else begin
      rx_ready_o <= (state_q != S_PUSH) & (state_q != S_SUM) & (state_q != S_DONE);
      // colon restarts parsing from any receive state
      if (take && rx_char_i == `CH_START) begin // [R1]
        state_q <= S_HEAD;
        nib_q   <= 1'b0;
        pos_q   <= `POS_LEN;
        sum_q   <= 8'h00;
        cnt_q   <= 8'h00;
      end else if (take && state_q != S_IDLE && dig[4]) begin
        // bad or lower-case digit drops the record
        error_o <= 1'b1; // [R3] [R14]
        state_q <= S_IDLE;
        nib_q   <= 1'b0;
      end else if (take && state_q != S_IDLE && !nib_q) begin
        hi_q  <= dig[3:0];
        nib_q <= 1'b1;
      end else if (byte_done) begin
        nib_q <= 1'b0;
        sum_q <= sum_q + byte_w; // [R6]
        case (state_q)
          S_HEAD: begin
            case (pos_q)
              `POS_LEN:     len_q <= byte_w; // [R9]
              `POS_ADDR_HI: addr_q[15:8] <= byte_w;
              `POS_ADDR_LO: addr_q[7:0] <= byte_w;
              default:      type_q <= byte_w;
            endcase
            pos_q <= pos_q + 3'h1;
            if (pos_q == `POS_TYPE) begin
              if (len_q > MAX_DATA[7:0]) begin
                error_o <= 1'b1;
                state_q <= S_IDLE;
              end else
                state_q <= S_DATA; // len data bytes, then the checksum byte
            end
          end
          S_DATA: begin
            if (cnt_q == len_q) begin
              // checksum byte closes the record; stop taking characters
              state_q    <= S_SUM;
              rx_ready_o <= 1'b0;
            end else begin
              dbuf_q[cnt_q] <= byte_w;
              case (cnt_q)
                8'h00:   pay0_q <= byte_w;
                8'h01:   pay1_q <= byte_w;
                8'h02:   pay2_q <= byte_w;
                8'h03:   pay3_q <= byte_w;
                default: pay3_q <= pay3_q;
              endcase
              cnt_q <= cnt_q + 8'h01;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end else if (state_q == S_SUM) begin
        // checksum byte already folded in; judge the record
        state_q    <= S_IDLE;
        rx_ready_o <= 1'b1;
        rd_q       <= 8'h00;
        if (sum_q != 8'h00)
          error_o <= 1'b1; // [R6] [R14]
        else if (type_q == `REC_DATA) begin
          // an empty data record is valid and writes nothing
          if (len_q != 8'h00) begin
            state_q    <= S_PUSH; // [R10]
            rx_ready_o <= 1'b0;
          end
        end else if (type_q == `REC_SEG && len_q == `LEN_SEG) begin
          seg_q <= {pay0_q, pay1_q}; // [R7] [R8]
        end else if (type_q == `REC_START && len_q == `LEN_START) begin
          start_addr_o  <= {pay0_q, pay1_q, 4'h0} + {4'h0, pay2_q, pay3_q}; // [R11]
          start_valid_o <= 1'b1;
        end else if (type_q == `REC_EOF && len_q == 8'h00) begin
          done_o     <= 1'b1; // [R12]
          state_q    <= S_DONE;
          rx_ready_o <= 1'b0;
        end else
          error_o <= 1'b1; // [R14]
      end else if (state_q == S_PUSH && buf_in_ready) begin
        rd_q <= rd_q + 8'h01;
        if (rd_q + 8'h01 == len_q) begin
          // ready follows the next state so no char lands in a busy state
          state_q    <= S_IDLE;
          rx_ready_o <= 1'b1;
        end
      end
      // other characters between records fall through untouched [R2]
    end
  end

  // ==========================================================
  // write buffer and memory port
  two_entry_buffer #(
    .WIDTH(28)
  ) u_wbuf (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .in_data_i   ({push_addr, dbuf_q[rd_q]}),
    .in_valid_i  (state_q == S_PUSH),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_out),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_pop)
  );

  // output register holding the write until accepted
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      mem_valid_o <= 1'b0;
      mem_addr_o  <= 20'h00000;
      mem_data_o  <= 8'h00;
    end else if (buf_pop) begin
      mem_valid_o <= 1'b1;
      mem_addr_o  <= buf_out[27:8];
      mem_data_o  <= buf_out[7:0];
    end else if (mem_ready_i)
      mem_valid_o <= 1'b0;
  end
endmodule

// [hw/two_entry_buffer.v]
// two-entry valid/ready buffer for load writes
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter WIDTH = 28
) (
  input  wire             core_clk_i, // clock
  input  wire             srst_i,     // sync reset
  input  wire [WIDTH-1:0] in_data_i,  // word in
  input  wire             in_valid_i, // word in valid
  output wire             in_ready_o, // space free
  output wire [WIDTH-1:0] out_data_o, // word out
  output wire             out_valid_o,// word out valid
  input  wire             out_ready_i // sink takes word
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_ptr_q;
  reg             rd_ptr_q;
  reg [1:0]       cnt_q;
  wire            push;
  wire            pop;

  // handshake terms
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_ptr_q];

  // storage and pointers
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_i;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule

// [tb/hex_loader_sva.sv]
// concurrent checks on the loader ports
`timescale 1ns/10ps
module hex_loader_sva (
  input wire logic        core_clk_i,    // clock
  input wire logic        srst_i,        // reset
  input wire logic        rx_ready_o,    // char ready
  input wire logic [19:0] mem_addr_o,    // write addr
  input wire logic [7:0]  mem_data_o,    // write byte
  input wire logic        mem_valid_o,   // write req
  input wire logic        mem_ready_i,   // write taken
  input wire logic [19:0] start_addr_o,  // start addr
  input wire logic        start_valid_o, // start seen
  input wire logic        done_o,        // end seen
  input wire logic        error_o        // error seen
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ==========================================================
  // write handshake
  sequence s_stall; mem_valid_o && !mem_ready_i; endsequence
  property p_hold; s_stall |=> mem_valid_o && $stable({mem_addr_o, mem_data_o}); endproperty
  a_hold: assert property (p_hold) else $error("write moved in stall");
  // ==========================================================
  // sticky status
  property p_done; done_o |=> done_o; endproperty
  a_done: assert property (p_done) else $error("done dropped");
  property p_quiet; done_o |-> !rx_ready_o; endproperty
  a_quiet: assert property (p_quiet) else $error("ready after end");
  property p_err; error_o |=> error_o; endproperty
  a_err: assert property (p_err) else $error("error dropped");
  property p_start; start_valid_o |=> start_valid_o; endproperty
  a_start: assert property (p_start) else $error("start flag dropped");
  property p_stamp; $rose(start_valid_o) |=> $stable(start_addr_o); endproperty
  a_stamp: assert property (p_stamp) else $error("start addr late");
  // ==========================================================
  // reset release
  sequence s_rel; $fell(srst_i); endsequence
  property p_rst; s_rel |-> !(done_o || error_o || start_valid_o || mem_valid_o); endproperty
  a_rst: assert property (p_rst) else $error("flag set out of reset");
  property p_ready; s_rel |=> rx_ready_o; endproperty
  a_ready: assert property (p_ready) else $error("not ready after reset");
endmodule
bind hex_record_loader hex_loader_sva i_sva (.*);

// [tb/mem_sink.sv]
// local memory model taking loader writes, stalls on request
`timescale 1ns/10ps
module mem_sink (
  input  wire logic        core_clk_i,  // clock
  input  wire logic [19:0] mem_addr_i,  // write addr
  input  wire logic [7:0]  mem_data_i,  // write byte
  input  wire logic        mem_valid_i, // write req
  input  wire logic        stall_i,     // hold off
  output wire logic        mem_ready_o  // write taken
);
  logic [7:0] mem [0:1048575];
  int         n_wr = 0;
  assign mem_ready_o = !stall_i;
  // store each byte taken at an edge
  always @(posedge core_clk_i) begin
    if (mem_valid_i && mem_ready_o) begin
      mem[mem_addr_i] <= mem_data_i;
      n_wr <= n_wr + 1;
    end
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the hex record loader
`timescale 1ns/10ps
module testbench;
  logic        core_clk_i = 0;
  logic        srst_i = 1;
  logic [7:0]  rx_char_i = 8'h00;
  logic        rx_valid_i = 0;
  logic        stall = 0;
  logic [7:0]  cyc = 8'h00;
  wire         rx_ready_o, mem_valid_o, mem_ready_i, start_valid_o, done_o, error_o;
  wire  [19:0] mem_addr_o, start_addr_o;
  wire  [7:0]  mem_data_o;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_exp = 0;
  logic [31:0] lfsr = 32'h0356;
  logic [15:0] seg = 16'h0000;
  logic [7:0]  d [0:15];
  always #50 core_clk_i = ~core_clk_i;
  hex_record_loader i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .rx_char_i(rx_char_i),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o), .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i),
    .start_addr_o(start_addr_o), .start_valid_o(start_valid_o), .done_o(done_o),
    .error_o(error_o));
  mem_sink i_mem (.core_clk_i(core_clk_i), .mem_addr_i(mem_addr_o), .mem_data_i(mem_data_o),
    .mem_valid_i(mem_valid_o), .stall_i(stall), .mem_ready_o(mem_ready_i));
  // memory stalls in bursts
  always @(posedge core_clk_i) begin
    cyc <= cyc + 8'h01;
    stall <= cyc[2] & cyc[4];
  end
  function [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    rnd = lfsr;
  endfunction
  function [7:0] hx(input [3:0] v);
    hx = (v < 10) ? 8'h30 + v : 8'h37 + v; // upper case only
  endfunction
  function [19:0] ea(input [15:0] a, input int i);
    logic [15:0] o;
    o = a + i[15:0];
    ea = {seg, 4'h0} + {4'h0, o};
  endfunction
  task conclude;
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] c);
    int k;
    rx_char_i <= c;
    rx_valid_i <= 1'b1;
    k = 0;
    @(posedge core_clk_i);
    while (rx_ready_o !== 1'b1 && k < 3000) begin
      k++;
      @(posedge core_clk_i);
    end
    if (k >= 3000) begin
      n_mismatch++;
      $display("[FAIL] %0t char not taken", $time);
      conclude();
    end
  endtask
  task automatic putb(input logic [7:0] b);
    put(hx(b[7:4]));
    put(hx(b[3:0]));
  endtask
  task automatic rec(input logic [7:0] t, input logic [15:0] a, input int n, input logic [7:0] e);
    logic [7:0] s;
    put(8'h0D);
    put(8'h00);
    put(8'h3A);
    s = n[7:0] + a[15:8] + a[7:0] + t;
    putb(n[7:0]);
    putb(a[15:8]);
    putb(a[7:0]);
    putb(t);
    for (int i = 0; i < n; i++) begin
      putb(d[i]);
      s += d[i];
    end
    putb((8'h00 - s) ^ e);
    rx_valid_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic settle();
    for (int k = 0; k < 3000 && i_mem.n_wr != n_exp; k++) @(posedge core_clk_i);
    repeat (10) @(posedge core_clk_i);
    chk(20'(i_mem.n_wr), 20'(n_exp), "write count");
  endtask
  // main sequence
  initial begin
    logic [31:0] x;
    logic [15:0] a;
    int          n;
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    chk({done_o, error_o, start_valid_o}, 20'h0, "reset flags");
    for (int r = 0; r < 8; r++) begin
      x = rnd();
      if (r % 3 == 2) begin
        d[0] = x[15:8];
        d[1] = x[7:0];
        rec(8'h02, 16'h0000, 2, 8'h00);
        seg = x[15:0];
      end
      for (int i = 0; i < 16; i++) d[i] = 8'(rnd());
      n = (r == 0) ? 16 : x[19:16] % 9;
      a = (r == 7) ? 16'hFFFE : x[31:16];
      rec(8'h00, a, n, 8'h00);
      n_exp += n;
      settle();
      for (int i = 0; i < n; i++) chk(20'(i_mem.mem[ea(a, i)]), 20'(d[i]), "byte");
    end
    rec(8'h00, 16'h0040, 4, 8'h01);
    rec(8'h05, 16'h0040, 4, 8'h00);
    settle();
    chk(20'(error_o), 20'h1, "error flag");
    x = rnd();
    for (int i = 0; i < 4; i++) d[i] = x[31-8*i -: 8];
    rec(8'h03, 16'h0000, 4, 8'h00);
    rec(8'h01, 16'h0000, 0, 8'h00);
    settle();
    chk(start_addr_o, {x[31:16], 4'h0} + {4'h0, x[15:0]}, "start addr");
    chk({start_valid_o, done_o, rx_ready_o}, 20'h6, "end state");
    conclude();
  end
endmodule
